// ==== rtl/uart_mode_status_defines.vh ====
`ifndef UART_MODE_STATUS_DEFINES_VH
`define UART_MODE_STATUS_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_DATA 8'h00
`define OFF_MCR 8'h04
`define OFF_FORMAT 8'h08
`define OFF_EXT_CTL 8'h0c
`define OFF_FIFO_CTL 8'h10
`define OFF_LINK_STATE 8'h14

// ----------------------------------------
// Mode and line control fields
// ----------------------------------------
`define MCR_DTR 0
`define MCR_RTS 1
`define MCR_B2 2
`define MCR_B3 3
`define MCR_LOOP 4
`define MCR_MODE_LO 5
`define MCR_MODE_HI 7
`define MCR_RESET 8'h00

// ----------------------------------------
// Format, extended control and FIFO control fields
// ----------------------------------------
`define FMT_WLS_LO 0
`define FMT_WLS_HI 1
`define FMT_PEN 3
`define FMT_EPS 4
`define FMT_STKP 5
`define FMT_LS_IE 6
`define EXT_MODE 0
`define EXT_LOOP 4
`define FCTL_FIFO_EN 0
`define FCTL_RX_RST 1
`define FCTL_TX_RST 2

// ----------------------------------------
// Link state bits
// ----------------------------------------
`define LS_RECEIVE_DATA_PRESENT 0
`define LS_OVR 1
`define LS_PAR 2
`define LS_FRM 3
`define LS_BRK 4
`define LS_THE 5
`define LS_IDLE 6
`define LS_QERR 7
`define LS_RESET 8'h60

// ----------------------------------------
// Operating modes
// ----------------------------------------
`define MODE_SERIAL 3'h0
`define MODE_ASK_IR 3'h2
`define MODE_SER_IR 3'h3
`define MODE_CONS_IR 3'h6

// ----------------------------------------
// Timing counts in oversample ticks and bit times
// ----------------------------------------
`define TICK_LAST 4'hf
`define TICK_HALF 4'h7
`define DEFER_BITS 4'h4

`endif

// ==== rtl/rx_status_queue.v ====
`timescale 1ns/100ps
`default_nettype none

module rx_status_queue #(
  parameter DW = 11,
  parameter AW = 4
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire flush,
  input wire push,
  input wire [DW-1:0] push_data,
  input wire pop,
  // Status
  output wire [DW-1:0] head_data,
  output wire empty,
  output wire full,
  output wire err_any
);
  localparam DEPTH = 1 << AW;

  reg [DW-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  reg [AW:0] err_q;

  wire do_push = push && !full;
  wire do_pop = pop && !empty;
  wire push_err = |push_data[DW-1:DW-3];
  wire pop_err = |head_data[DW-1:DW-3];

  assign head_data = mem[rd_q];
  assign empty = (cnt_q == {(AW+1){1'b0}});
  assign full = (cnt_q == DEPTH[AW:0]);
  // Errored entries are counted so the queue-error flag tracks contents
  assign err_any = (err_q != {(AW+1){1'b0}});

  always @(posedge pclk) begin
    if (do_push) begin
      mem[wr_q] <= push_data;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      err_q <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      err_q <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_pop) begin
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
      err_q <= err_q + {{AW{1'b0}}, do_push & push_err} - {{AW{1'b0}}, do_pop & pop_err};
    end
  end
endmodule

`default_nettype wire

// ==== rtl/uart_mode_status.v ====
// Behaviour
// RULE1: Legacy layout: bit 2 drives ring input during loopback, unused otherwise.
// RULE2: Legacy, no loopback: bit 3 gates the interrupt output.
// RULE3: Loopback: interrupt always enabled; bit 3 drives carrier detect input.
// RULE4: Legacy bit 4 enables loopback, reset 0, same storage as extended control bit 4.
// RULE5: Extended mode: interrupt always enabled; loopback only via extended control bit 4.
// RULE6: Extended: bit0 drives DTR low, bit1 RTS low; loopback feeds DSR/RI and CTS/DCD.
// RULE7: Extended bit 2 enables DMA; DMA always hits data holding registers.
// RULE8: Extended bit 3 enables transmit deferral, only while transmit FIFO enabled.
// RULE9: Bits 7-5 select mode: serial, ASK infrared, serial infrared, consumer infrared.
// RULE10: Mode change flushes FIFOs, clears status interrupts and auxiliary register; the code has no auxiliary register to clear.
// RULE11: Status bits 1-4 are sticky; cleared by reset, receiver reset or read.
// RULE12: Link state register resets to 0x60.
// RULE13: Any of status bits 4-1 set raises link status interrupt if enabled.
// RULE14: Software never writes the link state register.
// RULE15: Bit 0 set while receive holding register or FIFO holds data.
// RULE16: Character arriving while full is dropped and sets overrun bit 1.
// RULE17: Bit 2 flags parity error when the character reaches the FIFO bottom.
// RULE18: Bit 3 flags zero stop bit; next 0 is a start bit, next 1 idles.
// RULE19: Bit 4 flags break; one zero character stored; resume after mark then start.
// RULE20: Bit 5 set when transmit holding empty, cleared by data write.
// RULE21: Bit 6 set when transmit holding empty and shifter idle.
// RULE22: Bit 7 set while receive FIFO holds an errored character; 0 without FIFO.
`timescale 1ns/100ps
`default_nettype none
`include "uart_mode_status_defines.vh"

module uart_mode_status #(
  parameter BAUD16_DIV = 13,
  parameter QUEUE_AW = 4
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Serial line
  input wire sin,
  output reg sout,
  // Modem lines
  input wire cts_n,
  input wire dsr_n,
  input wire ri_n,
  input wire dcd_n,
  output reg dtr_n,
  output reg rts_n,
  output wire seen_cts_n,
  output wire seen_dsr_n,
  output wire seen_ri_n,
  output wire seen_dcd_n,
  // Interrupt
  input wire irq_source,
  output wire irq_out,
  output wire link_status_event,
  // DMA
  input wire dma_ack,
  input wire dma_write,
  input wire [7:0] dma_wdata,
  output reg [7:0] dma_rdata,
  output wire dma_enable,
  // Mode
  output wire [2:0] operating_mode,
  output wire extended_mode,
  output wire send_deferral_active,
  output reg mode_change_flush
);
  // ----------------------------------------
  // Receiver states
  // ----------------------------------------
  localparam R_IDLE = 3'd0;
  localparam R_START = 3'd1;
  localparam R_DATA = 3'd2;
  localparam R_PAR = 3'd3;
  localparam R_STOP = 3'd4;
  localparam R_RESYNC = 3'd5;
  localparam R_MARK = 3'd6;

  function parity_bit;
    input [7:0] d;
    input [1:0] wls;
    input eps;
    input stkp;
    reg [7:0] m;
    begin
      case (wls)
        2'h0: m = d & 8'h1f;
        2'h1: m = d & 8'h3f;
        2'h2: m = d & 8'h7f;
        default: m = d;
      endcase
      if (stkp) begin
        parity_bit = ~eps;
      end else begin
        parity_bit = eps ? ^m : ~^m;
      end
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [3:0] mcr_low_q;
  reg loop_q;
  reg [2:0] mode_q;
  reg ext_q;
  reg [6:0] fmt_q;
  reg fifo_en_q;
  reg [3:0] sticky_q;
  reg [7:0] lsr_snap_q;
  reg [7:0] tx_hold_q;
  reg tx_full_q;
  reg [10:0] tx_frame_q;
  reg [3:0] tx_left_q;
  reg tx_busy_q;
  reg [3:0] defer_q;
  reg [7:0] tick_div_q;
  reg [3:0] bit_div_q;
  reg [2:0] rx_st_q;
  reg [3:0] rx_tick_q;
  reg [2:0] rx_cnt_q;
  reg [7:0] rx_shift_q;
  reg rx_zero_q;
  reg rx_perr_q;
  reg head_seen_q;
  reg [10:0] tx_frame_d;
  reg [7:0] rd_mux;
  reg [7:0] mcr_view;
  reg rx_done;
  reg [2:0] rx_flags;
  integer i;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire hit_data = (paddr == `OFF_DATA);
  wire hit_mcr = (paddr == `OFF_MCR);
  wire hit_fmt = (paddr == `OFF_FORMAT);
  wire hit_ext = (paddr == `OFF_EXT_CTL);
  wire hit_fctl = (paddr == `OFF_FIFO_CTL);
  wire hit_lsr = (paddr == `OFF_LINK_STATE);
  wire mapped = hit_data | hit_mcr | hit_fmt | hit_ext | hit_fctl | hit_lsr;
  wire wr_ok = access && pwrite && mapped && !hit_lsr;
  wire rd_lsr = access && !pwrite && hit_lsr;
  wire rd_data = access && !pwrite && hit_data;

  assign pready = 1'b1;
  assign pslverr = access && (!mapped || (pwrite && hit_lsr)); // see RULE14

  wire [2:0] new_mode = pwdata[`MCR_MODE_HI:`MCR_MODE_LO];
  wire mode_chg = wr_ok && hit_mcr && ext_q && (new_mode != mode_q); // see RULE10
  wire rx_rst = (wr_ok && hit_fctl && pwdata[`FCTL_RX_RST]) || mode_chg;
  wire tx_rst = (wr_ok && hit_fctl && pwdata[`FCTL_TX_RST]) || mode_chg;

  // ----------------------------------------
  // Mode, modem lines and interrupt gate
  // ----------------------------------------
  assign extended_mode = ext_q;
  assign operating_mode = ext_q ? mode_q : `MODE_SERIAL; // see RULE9
  assign dma_enable = ext_q && mcr_low_q[`MCR_B2]; // see RULE7
  assign send_deferral_active = ext_q && mcr_low_q[`MCR_B3] && fifo_en_q; // see RULE8

  // Loopback drives inputs low when the control bit is 1, like the pins would
  assign seen_dsr_n = loop_q ? ~mcr_low_q[`MCR_DTR] : dsr_n; // see RULE6
  assign seen_cts_n = loop_q ? ~mcr_low_q[`MCR_RTS] : cts_n; // see RULE6
  assign seen_ri_n = !loop_q ? ri_n :
                     ext_q ? ~mcr_low_q[`MCR_DTR] : ~mcr_low_q[`MCR_B2]; // see RULE1
  assign seen_dcd_n = !loop_q ? dcd_n :
                      ext_q ? ~mcr_low_q[`MCR_RTS] : ~mcr_low_q[`MCR_B3]; // see RULE3

  assign link_status_event = fmt_q[`FMT_LS_IE] && (|sticky_q); // see RULE13
  // Gate only bites in legacy mode with loopback off
  assign irq_out = (irq_source | link_status_event) &&
                   (ext_q || loop_q || mcr_low_q[`MCR_B3]); // see RULE2

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcr_low_q <= 4'h0;
      loop_q <= 1'b0;
      mode_q <= `MODE_SERIAL;
      ext_q <= 1'b0;
      fmt_q <= 7'h00;
      fifo_en_q <= 1'b0;
      mode_change_flush <= 1'b0;
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
    end else begin
      mode_change_flush <= mode_chg;
      // Outputs parked inactive while looped back
      dtr_n <= ~(mcr_low_q[`MCR_DTR] && !loop_q); // see RULE6
      rts_n <= ~(mcr_low_q[`MCR_RTS] && !loop_q); // see RULE6
      if (wr_ok && hit_mcr) begin
        mcr_low_q <= pwdata[3:0];
        if (ext_q) begin
          mode_q <= new_mode; // see RULE9
        end else begin
          loop_q <= pwdata[`MCR_LOOP]; // see RULE4
        end
      end
      if (wr_ok && hit_ext) begin
        ext_q <= pwdata[`EXT_MODE];
        loop_q <= pwdata[`EXT_LOOP]; // see RULE5
      end
      if (wr_ok && hit_fmt) begin
        fmt_q <= pwdata[6:0];
      end
      if (wr_ok && hit_fctl) begin
        fifo_en_q <= pwdata[`FCTL_FIFO_EN];
      end
    end
  end

  // ----------------------------------------
  // Receive queue and link state
  // ----------------------------------------
  wire [10:0] head;
  wire q_empty;
  wire q_full;
  wire q_err;
  wire dma_rx = dma_ack && !dma_write && dma_enable; // see RULE7
  wire rx_pop = (rd_data || dma_rx) && !q_empty;
  wire full_eff = fifo_en_q ? q_full : !q_empty;
  wire rx_push = rx_done && !full_eff;
  wire reveal = !q_empty && !head_seen_q;

  rx_status_queue #(
    .DW(11),
    .AW(QUEUE_AW)
  ) u_rxq (
    .pclk(pclk),
    .presetn(presetn),
    .flush(rx_rst),
    .push(rx_push),
    .push_data({rx_flags, rx_shift_q}),
    .pop(rx_pop),
    .head_data(head),
    .empty(q_empty),
    .full(q_full),
    .err_any(q_err)
  );

  wire [7:0] lsr_now = {fifo_en_q && q_err, // see RULE22
                        !tx_full_q && !tx_busy_q, // see RULE21
                        !tx_full_q, // see RULE20
                        sticky_q,
                        !q_empty}; // see RULE15
  // Flags raised after the snapshot survive the clearing read
  wire [3:0] sticky_set = {reveal ? head[10:8] : 3'h0, rx_done && full_eff}; // see RULE16
  wire [3:0] sticky_clr = rd_lsr ? lsr_snap_q[4:1] : 4'h0;

  always @* begin
    mcr_view = ext_q ? {mode_q, 1'b0, mcr_low_q} : {3'h0, loop_q, mcr_low_q};
    rd_mux = 8'h00;
    if (hit_data) rd_mux = head[7:0];
    if (hit_mcr) rd_mux = mcr_view;
    if (hit_fmt) rd_mux = {1'b0, fmt_q};
    if (hit_ext) rd_mux = {3'h0, loop_q, 3'h0, ext_q};
    if (hit_fctl) rd_mux = {7'h00, fifo_en_q};
    if (hit_lsr) rd_mux = lsr_now;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      lsr_snap_q <= `LS_RESET; // see RULE12
      sticky_q <= 4'h0;
      head_seen_q <= 1'b0;
      dma_rdata <= 8'h00;
    end else begin
      if (setup) begin
        prdata <= {24'h000000, rd_mux};
        lsr_snap_q <= lsr_now;
      end
      if (rx_rst) begin
        sticky_q <= 4'h0; // see RULE11
        head_seen_q <= 1'b0;
      end else begin
        sticky_q <= (sticky_q & ~sticky_clr) | sticky_set; // see RULE11
        if (rx_pop) begin
          head_seen_q <= 1'b0; // see RULE17
        end else if (reveal) begin
          head_seen_q <= 1'b1;
        end
      end
      if (dma_rx) begin
        dma_rdata <= head[7:0];
      end
    end
  end

  // ----------------------------------------
  // Baud ticks
  // ----------------------------------------
  wire tick16 = (tick_div_q == BAUD16_DIV[7:0] - 8'h01);
  wire bit_tick = tick16 && (bit_div_q == `TICK_LAST);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_div_q <= 8'h00;
      bit_div_q <= 4'h0;
    end else begin
      tick_div_q <= tick16 ? 8'h00 : tick_div_q + 8'h01;
      if (tick16) begin
        bit_div_q <= bit_div_q + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  wire [3:0] nbits = 4'd5 + {2'b00, fmt_q[`FMT_WLS_HI:`FMT_WLS_LO]};
  wire pen = fmt_q[`FMT_PEN];
  wire dma_tx = dma_ack && dma_write && dma_enable; // see RULE7
  wire tx_wr = (wr_ok && hit_data) || dma_tx;
  wire [7:0] tx_wdata = (wr_ok && hit_data) ? pwdata[7:0] : dma_wdata;
  wire defer_ok = !send_deferral_active || (defer_q == `DEFER_BITS); // see RULE8
  wire tx_load = bit_tick && tx_full_q && !tx_busy_q && defer_ok;
  wire tx_line = tx_busy_q ? tx_frame_q[0] : 1'b1;

  always @* begin
    tx_frame_d = 11'h7ff;
    tx_frame_d[0] = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      if (i < nbits) tx_frame_d[i + 1] = tx_hold_q[i];
    end
    if (pen) begin
      tx_frame_d[nbits + 4'd1] = parity_bit(tx_hold_q, fmt_q[1:0], fmt_q[`FMT_EPS],
                                            fmt_q[`FMT_STKP]);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hold_q <= 8'h00;
      tx_full_q <= 1'b0;
      tx_frame_q <= 11'h7ff;
      tx_left_q <= 4'h0;
      tx_busy_q <= 1'b0;
      defer_q <= 4'h0;
      sout <= 1'b1;
    end else begin
      sout <= loop_q ? 1'b1 : tx_line;
      if (tx_rst) begin
        tx_full_q <= 1'b0;
      end else if (tx_wr && !tx_full_q) begin
        tx_hold_q <= tx_wdata;
        tx_full_q <= 1'b1; // see RULE20
      end else if (tx_load) begin
        tx_full_q <= 1'b0;
      end
      if (tx_wr) begin
        defer_q <= 4'h0;
      end else if (bit_tick && defer_q != `DEFER_BITS) begin
        defer_q <= defer_q + 4'h1;
      end
      if (tx_load) begin
        tx_frame_q <= tx_frame_d;
        tx_left_q <= nbits + {3'b000, pen} + 4'd1;
        tx_busy_q <= 1'b1;
      end else if (bit_tick && tx_busy_q) begin
        tx_frame_q <= {1'b1, tx_frame_q[10:1]};
        tx_left_q <= tx_left_q - 4'h1;
        if (tx_left_q == 4'h0) begin
          tx_busy_q <= 1'b0; // see RULE21
        end
      end
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  wire rx_in = loop_q ? tx_line : sin;
  wire err_mode = (operating_mode != `MODE_CONS_IR);
  wire rx_mid = tick16 && (rx_tick_q == `TICK_LAST);

  always @* begin
    rx_done = 1'b0;
    rx_flags = 3'h0;
    if (rx_st_q == R_STOP && rx_mid) begin
      rx_done = 1'b1;
      if (err_mode) begin
        rx_flags = {!rx_in && rx_zero_q, !rx_in && !rx_zero_q, rx_perr_q};
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q <= R_IDLE;
      rx_tick_q <= 4'h0;
      rx_cnt_q <= 3'h0;
      rx_shift_q <= 8'h00;
      rx_zero_q <= 1'b0;
      rx_perr_q <= 1'b0;
    end else if (rx_rst) begin
      rx_st_q <= R_IDLE;
      rx_tick_q <= 4'h0;
    end else if (tick16) begin
      rx_tick_q <= rx_tick_q + 4'h1;
      case (rx_st_q)
        R_IDLE: begin
          rx_tick_q <= 4'h0;
          if (!rx_in) rx_st_q <= R_START;
        end
        R_START: begin
          if (rx_tick_q == `TICK_HALF) begin
            rx_tick_q <= 4'h0;
            rx_cnt_q <= 3'h0;
            rx_shift_q <= 8'h00;
            rx_zero_q <= 1'b1;
            rx_perr_q <= 1'b0;
            rx_st_q <= rx_in ? R_IDLE : R_DATA;
          end
        end
        R_DATA: begin
          if (rx_mid) begin
            rx_shift_q[rx_cnt_q] <= rx_in;
            rx_zero_q <= rx_zero_q & !rx_in;
            rx_cnt_q <= rx_cnt_q + 3'h1;
            if ({1'b0, rx_cnt_q} == nbits - 4'd1) rx_st_q <= pen ? R_PAR : R_STOP;
          end
        end
        R_PAR: begin
          if (rx_mid) begin
            rx_perr_q <= (rx_in != parity_bit(rx_shift_q, fmt_q[1:0], fmt_q[`FMT_EPS],
                                              fmt_q[`FMT_STKP])); // see RULE17
            rx_zero_q <= rx_zero_q & !rx_in;
            rx_st_q <= R_STOP;
          end
        end
        R_STOP: begin
          if (rx_mid) begin
            if (rx_in) rx_st_q <= R_IDLE;
            else if (rx_zero_q) rx_st_q <= R_MARK; // see RULE19
            else rx_st_q <= R_RESYNC; // see RULE18
          end
        end
        R_RESYNC: begin
          if (rx_mid) begin
            rx_cnt_q <= 3'h0;
            rx_shift_q <= 8'h00;
            rx_zero_q <= 1'b1;
            rx_perr_q <= 1'b0;
            rx_st_q <= rx_in ? R_IDLE : R_DATA; // see RULE18
          end
        end
        R_MARK: begin
          if (rx_in) rx_st_q <= R_IDLE; // see RULE19
        end
        default: rx_st_q <= R_IDLE;
      endcase
    end
  end
endmodule

`default_nettype wire

// ==== bench/uart_mode_status_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "uart_mode_status_defines.vh"
// ------------------------------
// Port checks
// ------------------------------
module uart_mode_status_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Mode and interrupt
  input wire logic irq_source,
  input wire logic irq_out,
  input wire logic link_status_event,
  input wire logic dma_enable,
  input wire logic [2:0] operating_mode,
  input wire logic extended_mode,
  input wire logic send_deferral_active,
  input wire logic mode_change_flush
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  ext_irq_a: assert property (extended_mode |->
    irq_out == (irq_source | link_status_event)) else $error("irq gated in ext");
  dma_gate_a: assert property (!extended_mode |-> !dma_enable)
    else $error("dma on in legacy");
  defer_gate_a: assert property (!extended_mode |-> !send_deferral_active)
    else $error("deferral on in legacy");
  legacy_mode_a: assert property (!extended_mode |->
    operating_mode == `MODE_SERIAL) else $error("mode set in legacy");
  mode_flush_a: assert property (extended_mode && $past(extended_mode) &&
    operating_mode != $past(operating_mode) |-> ##[0:1] mode_change_flush)
    else $error("no flush on mode change");
  flush_ext_a: assert property ($rose(mode_change_flush) |->
    extended_mode ##1 !mode_change_flush) else $error("bad flush pulse");
  ro_write_a: assert property (acc && pwrite &&
    paddr == `OFF_LINK_STATE |-> pslverr) else $error("status write accepted");
  zero_wait_a: assert property (acc |-> pready && prdata[31:8] == 24'h0)
    else $error("bad apb answer");
  cover property (mode_change_flush);
  cover property (link_status_event);
  cover property (dma_enable && send_deferral_active == 1'b0);
endmodule
bind uart_mode_status uart_mode_status_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq_source(irq_source), .irq_out(irq_out),
  .link_status_event(link_status_event), .dma_enable(dma_enable),
  .operating_mode(operating_mode), .extended_mode(extended_mode),
  .send_deferral_active(send_deferral_active), .mode_change_flush(mode_change_flush)
);
`default_nettype wire

// ==== bench/serial_line_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// Far end of the line
// ------------------------------
module serial_line_model #(
  parameter int BIT = 16
) (
  // Clock
  input wire logic pclk,
  // Serial
  input wire logic sout,
  output logic sin,
  // Modem lines
  output logic cts_n,
  output logic dsr_n,
  output logic ri_n,
  output logic dcd_n
);
  logic [3:0] modem_n = 4'hf;
  logic [7:0] rx_byte;
  assign {dcd_n, ri_n, dsr_n, cts_n} = modem_n;
  initial sin = 1'b1;
  // Frame LSB first, then one idle mark bit so the receiver resyncs
  task send(input logic [23:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk) sin <= f[i];
      repeat (BIT - 1) @(posedge pclk);
    end
    @(posedge pclk) sin <= 1'b1;
    repeat (BIT) @(posedge pclk);
  endtask
  initial forever begin
    @(negedge sout);
    repeat (BIT + BIT / 2) @(posedge pclk);
    for (int j = 0; j < 8; j++) begin
      rx_byte[j] = sout;
      repeat (BIT) @(posedge pclk);
    end
  end
endmodule
`default_nettype wire

// ==== bench/test_uart_mode_control_and_link_status.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "uart_mode_status_defines.vh"
module test_uart_mode_control_and_link_status;
  localparam int BIT = 16;
  localparam logic [7:0] DT = `OFF_DATA, MC = `OFF_MCR, FM = `OFF_FORMAT;
  localparam logic [7:0] EX = `OFF_EXT_CTL, FC = `OFF_FIFO_CTL, LS = `OFF_LINK_STATE;
  localparam logic [11:0] MODES = {`MODE_SERIAL, `MODE_CONS_IR, `MODE_SER_IR, `MODE_ASK_IR};
  logic pclk, presetn, psel, penable, pwrite, irq_source, dma_ack, dma_write, err;
  logic [7:0] paddr, dma_wdata;
  logic [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire [7:0] dma_rdata;
  wire [2:0] op_mode;
  wire pready, pslverr, sin, sout, dtr_n, rts_n, cts_n, dsr_n, ri_n, dcd_n;
  wire s_cts_n, s_dsr_n, s_ri_n, s_dcd_n, irq_out, lse, dma_en, ext, defer, flush;
  int n_errors = 0, tests_run = 0, cycles = 0;
  uart_mode_status #(.BAUD16_DIV(1), .QUEUE_AW(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sin(sin), .sout(sout), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n),
    .dtr_n(dtr_n), .rts_n(rts_n), .seen_cts_n(s_cts_n), .seen_dsr_n(s_dsr_n),
    .seen_ri_n(s_ri_n), .seen_dcd_n(s_dcd_n), .irq_source(irq_source), .irq_out(irq_out),
    .link_status_event(lse), .dma_ack(dma_ack), .dma_write(dma_write),
    .dma_wdata(dma_wdata), .dma_rdata(dma_rdata), .dma_enable(dma_en),
    .operating_mode(op_mode), .extended_mode(ext), .send_deferral_active(defer),
    .mode_change_flush(flush));
  serial_line_model #(.BIT(BIT)) u_line (.pclk(pclk), .sout(sout), .sin(sin),
    .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n));
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors = n_errors + 1;
      wrap_up();
    end
  end
  // ------------------------------
  // Shared tasks
  // ------------------------------
  task wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task ck(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task w(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    ck(rd & m, e);
  endtask
  task st();
    @(posedge pclk);
    #1;
  endtask
  task wl(input logic [7:0] m, input logic [7:0] v);
    for (int i = 0; i < 400; i++) begin
      apb(1'b0, LS, 32'h0);
      if ((rd[7:0] & m) == v) break;
    end
    ck(rd[7:0] & m, v);
  endtask
  task rx(input logic [23:0] f, input int n);
    u_line.send(f, n);
    repeat (4) st();
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task t_reset();
    rm(LS, 32'hffffffff, 32'h60);
    rm(MC, 32'hffffffff, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    ck(err, 1'b1);
    w(LS, 32'h0);
    ck(err, 1'b1);
    rm(LS, 32'hff, 32'h60);
    $display("reset done");
  endtask
  task t_legacy();
    w(FM, 32'h03);
    irq_source <= 1'b1;
    w(MC, 32'h03);
    st();
    ck({dtr_n, rts_n, irq_out}, 3'b000);
    w(MC, 32'he8);
    st();
    ck(irq_out, 1'b1);
    rm(MC, 32'hff, 32'h08);
    $display("legacy done");
  endtask
  task t_loop();
    u_line.modem_n <= 4'h0;
    w(MC, 32'h1c);
    st();
    ck({s_dcd_n, s_ri_n, s_cts_n, s_dsr_n}, 4'b0011);
    w(MC, 32'h10);
    st();
    ck(irq_out, 1'b1);
    rm(EX, 32'h10, 32'h10);
    w(MC, 32'h0);
    st();
    ck(irq_out, 1'b0);
    ck({s_dcd_n, s_ri_n, s_cts_n, s_dsr_n}, 4'h0);
    $display("loopback done");
  endtask
  task t_ext();
    int k;
    w(EX, 32'h01);
    w(MC, 32'h07);
    st();
    ck({ext, dtr_n, rts_n, dma_en, irq_out}, 5'b10011);
    w(MC, 32'h11);
    rm(EX, 32'h10, 32'h0);
    w(EX, 32'h11);
    w(MC, 32'h01);
    st();
    ck({s_dcd_n, s_ri_n, s_cts_n, s_dsr_n}, 4'b1010);
    w(EX, 32'h01);
    for (k = 0; k < 4; k++) begin
      w(MC, {24'h0, MODES[3*k +: 3], 5'h0});
      st();
      ck(op_mode, MODES[3*k +: 3]);
    end
    $display("extended done");
  endtask
  task t_tx();
    w(FC, 32'h01);
    w(MC, 32'h08);
    st();
    ck(defer, 1'b1);
    w(DT, 32'ha5);
    rm(LS, 32'h60, 32'h0);
    repeat (2 * BIT) st();
    rm(LS, 32'h20, 32'h0);
    wl(8'h20, 8'h20);
    ck(rd[6], 1'b0);
    wl(8'h40, 8'h40);
    ck(u_line.rx_byte, 8'ha5);
    w(FC, 32'h0);
    st();
    ck(defer, 1'b0);
    $display("transmit done");
  endtask
  task t_rx();
    w(MC, 32'h0);
    w(EX, 32'h0);
    rx({1'b1, 8'h5a, 1'b0}, 10);
    rm(LS, 32'h01, 32'h01);
    rx({1'b1, 8'hc3, 1'b0}, 10);
    rm(LS, 32'h02, 32'h02);
    rm(LS, 32'h02, 32'h0);
    rm(DT, 32'hff, 32'h5a);
    rm(LS, 32'h81, 32'h0);
    w(FC, 32'h01);
    w(FM, 32'h4b);
    rx({1'b1, 1'b1, 8'h01, 1'b0}, 11);
    ck(lse, 1'b1);
    rm(LS, 32'h85, 32'h85);
    rm(LS, 32'h84, 32'h80);
    rm(DT, 32'hff, 32'h01);
    rm(LS, 32'h81, 32'h0);
    rx({1'b0, 1'b1, 8'h03, 1'b0}, 11);
    rx({1'b1, 1'b0, 8'h07, 1'b0, 1'b0, 1'b1, 8'h03, 1'b0}, 22);
    rm(LS, 32'h08, 32'h08);
    rm(DT, 32'hff, 32'h03);
    rm(DT, 32'hff, 32'h03);
    rm(DT, 32'hff, 32'h07);
    rx(24'h0, 24);
    rm(LS, 32'h10, 32'h10);
    rm(DT, 32'hff, 32'h0);
    rm(LS, 32'h01, 32'h0);
    $display("receive done");
  endtask
  task t_dma();
    rx({1'b1, 1'b1, 8'h11, 1'b0}, 11);
    rx({1'b1, 1'b1, 8'h22, 1'b0}, 11);
    w(EX, 32'h01);
    w(MC, 32'h0c);
    @(posedge pclk) dma_ack <= 1'b1;
    @(posedge pclk) dma_write <= 1'b1;
    @(posedge pclk) dma_ack <= 1'b0;
    st();
    ck(dma_rdata, 8'h11);
    rm(LS, 32'h21, 32'h01);
    w(MC, 32'h64);
    st();
    rm(LS, 32'h7f, 32'h60);
    $display("dma done");
  endtask
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    irq_source = 0; dma_ack = 0; dma_write = 0; dma_wdata = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_legacy();
    t_loop();
    t_ext();
    t_tx();
    t_rx();
    t_dma();
    wrap_up();
  end
endmodule
`default_nettype wire
